// File: dv/odc_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------
// host software on the config port
// ---------------------------------------------
module odc_host_model (
    input  wire logic       ref_clk,    // register clock
    output logic            cfgWrEn,    // write strobe
    output logic            cfgRdEn,    // read strobe
    output logic [7:0]      cfgAddr,    // register number
    output logic [7:0]      cfgWrData,  // write byte
    input  wire logic [7:0] cfgRdData,  // read byte
    input  wire logic       cfgRdValid  // read valid
);
    // idle bus at time zero
    initial begin
        cfgWrEn = 1'b0;
        cfgRdEn = 1'b0;
        cfgAddr = 8'h00;
        cfgWrData = 8'h00;
    end
    // phase writes always carry full single-ended strength
    function automatic logic [7:0] phaseByte(input logic [1:0] code);
        return {code, 3'h0, 3'h7};
    endfunction
    // one write; bus scrambled afterwards so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cfgWrEn <= 1'b1;
        cfgAddr <= a;
        cfgWrData <= d;
        @(posedge ref_clk);
        cfgWrEn <= 1'b0;
        cfgAddr <= ~a;
        cfgWrData <= ~d;
    endtask
    // one read; answer taken at the edge after the strobe is taken
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        cfgRdEn <= 1'b1;
        cfgAddr <= a;
        @(posedge ref_clk);
        cfgRdEn <= 1'b0;
        cfgAddr <= ~a;
        @(posedge ref_clk);
        d = cfgRdData;
        v = cfgRdValid;
    endtask
endmodule

// File: dv/odc_output_config_properties.sv
`timescale 1ns/1ps
// ---------------------------------------------
// port checks of the output config bank
// ---------------------------------------------
module odc_out_chk (
    input wire logic                     ref_clk,          // register clock
    input wire logic                     sys_rst,          // async reset, high
    input wire logic                     cfgWrEn,          // write strobe
    input wire logic                     cfgRdEn,          // read strobe
    input wire logic [7:0]               cfgAddr,          // register number
    input wire logic [7:0]               cfgWrData,        // write byte
    input wire logic [7:0]               cfgRdData,        // read byte
    input wire logic                     cfgRdValid,       // read valid pulse
    input wire odc_pkg::odc_out_cfg_type out5Cfg,          // output 5 setup
    input wire odc_pkg::odc_out_cfg_type out6Cfg,          // output 6 setup
    input wire logic [33:0]              out6DividerValue  // output 6 divider
);
    logic [7:0] wd1_q;  // write byte one edge old
    logic [7:0] wd2_q;  // write byte two edges old
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // decoded fields land two edges after the write, so keep the byte that long
    always_ff @(posedge ref_clk) begin
        wd1_q <= cfgWrData;
        wd2_q <= wd1_q;
    end
    leg_decode_a: assert property (cfgWrEn && cfgAddr == 8'h43 |-> ##2
        out6Cfg.legs == {wd2_q[7], wd2_q[7] | ~wd2_q[6]}) else $error("leg sources wrong");
    coarse_delay_a: assert property (cfgWrEn && cfgAddr == 8'h3C |-> ##2
        out5Cfg.coarseDelay == wd2_q[5:0]) else $error("coarse delay wrong");
    fine_step_a: assert property (cfgWrEn && cfgAddr == 8'h44 |-> ##2
        out6Cfg.fineDelayCode == wd2_q[7:6] && out6Cfg.fineDelayPs == {5'h00, wd2_q[7:6]} * 7'h1E)
        else $error("fine delay wrong");
    supply_decode_a: assert property (cfgWrEn && cfgAddr == 8'h3D |-> ##2
        out5Cfg.supply == odc_pkg::odc_supply_type'(wd2_q[4:3])
        && out5Cfg.supplyBad == (wd2_q[4:3] == 2'h3)) else $error("supply decode wrong");
    driver_decode_a: assert property (cfgWrEn && cfgAddr == 8'h45 |-> ##2
        out6Cfg.driver == odc_pkg::odc_driver_type'(wd2_q[2:0] > 3'h5 ? 3'h6 : wd2_q[2:0])
        && out6Cfg.driverBad == (wd2_q[2:0] > 3'h5)) else $error("driver decode wrong");
    wide_bits_a: assert property (cfgWrEn && cfgAddr == 8'h45 |-> ##2
        out6DividerValue[33:32] == wd2_q[7:6]) else $error("divider top bits wrong");
    div_high_a: assert property (cfgWrEn && cfgAddr == 8'h40 |-> ##2
        out6DividerValue[19:16] == wd2_q[3:0]) else $error("divider high nibble wrong");
    div_low_a: assert property (cfgWrEn && cfgAddr == 8'h42 |-> ##2
        out6DividerValue[7:0] == wd2_q) else $error("divider low byte wrong");
    read_pulse_a: assert property (cfgRdValid == $past(cfgRdEn))
        else $error("read valid pulse wrong");
    unmapped_read_a: assert property (cfgRdEn && cfgAddr == 8'h3E |=>
        cfgRdValid && cfgRdData == 8'h00) else $error("unmapped read not zero");
endmodule

bind odc_output_config odc_out_chk chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .out5Cfg(out5Cfg),
    .out6Cfg(out6Cfg), .out6DividerValue(out6DividerValue));

// File: dv/test_output_divider_driver_config.sv
`timescale 1ns/1ps
module test_output_divider_driver_config;
    logic                     ref_clk, sys_rst, cfgWrEn, cfgRdEn, cfgRdValid, rdOk;
    logic [7:0]               cfgAddr, cfgWrData, cfgRdData, rdByte, d;
    logic [3:0]               c;
    logic [33:0]              out6DividerValue;
    odc_pkg::odc_out_cfg_type out5Cfg, out6Cfg;
    logic [7:0]               shadow [9];
    logic [7:0]               addrs [9] = '{8'h3B, 8'h3C, 8'h3D, 8'h40, 8'h41, 8'h42,
                                            8'h43, 8'h44, 8'h45};
    logic [31:0]              rnd;
    int                       nFail, nTests;

    odc_output_config dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cfgWrEn(cfgWrEn),
        .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid), .out5Cfg(out5Cfg), .out6Cfg(out6Cfg),
        .out6DividerValue(out6DividerValue));
    odc_host_model host (.ref_clk(ref_clk), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
        .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid));

    // ---------------------------------------------
    // expectations and checks
    // ---------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [7:0] maskOf(input logic [7:0] a);
        case (a)
            8'h3B, 8'h43: return 8'hC7;
            8'h3D: return 8'h1F;
            8'h45: return 8'hDF;
            default: return 8'hFF;
        endcase
    endfunction
    function automatic logic [1:0] expLegs(input logic [1:0] code);
        return {code[1], code[1] | ~code[0]};
    endfunction
    task automatic chkVal(input logic [33:0] got, input logic [33:0] exp);
        nTests++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    // read every register back and compare the assembled divider
    task automatic checkAll();
        for (int i = 0; i < 9; i++) begin
            host.rd(addrs[i], rdByte, rdOk);
            chkVal(rdOk, 1'b1);
            chkVal(rdByte, shadow[i]);
        end
        chkVal(out5Cfg.legs, expLegs(shadow[0][7:6]));
        chkVal(out6DividerValue, {shadow[8][7:6], 12'h000, shadow[3][3:0], shadow[4], shadow[5]});
    endtask
    task automatic closeOut();
        $display("tests=%0d mismatches=%0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (6000) @(posedge ref_clk);
        nFail++;
        closeOut();
    end

    // main sequence: reset, fill, code sweep, unmapped places, second reset
    initial begin
        sys_rst = 1'b1;
        rnd = 32'h0000_8016;
        nFail = 0;
        nTests = 0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        checkAll();
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 9; i++) begin
                rnd = lfsr(rnd);
                d = (r == 0) ? 8'hFF : rnd[7:0];
                host.wr(addrs[i], d);
                shadow[i] = d & maskOf(addrs[i]);
            end
            checkAll();
        end
        for (c = 4'h0; c < 4'h8; c++) begin
            host.wr(8'h43, host.phaseByte(c[1:0]));
            host.wr(8'h45, {c[1:0], 3'h0, c[2:0]});
            host.wr(8'h3D, {3'h0, c[1:0], c[2:0]});
            host.wr(8'h44, {c[1:0], 6'h3F});
            repeat (2) @(negedge ref_clk);
            chkVal(out6Cfg.legs, expLegs(c[1:0]));
            chkVal(out6Cfg.driveStrength, 3'h7);
            chkVal(out6Cfg.coarseDelay, 6'h3F);
            chkVal(out6Cfg.fineDelayPs, {5'h00, c[1:0]} * 7'h1E);
            chkVal(out5Cfg.supply, c[1:0]);
            chkVal(out5Cfg.supplyBad, c[1:0] == 2'h3);
            chkVal(out6Cfg.driver, (c[2:0] > 3'h5) ? 3'h6 : c[2:0]);
            chkVal(out6Cfg.driverBad, c[2:0] > 3'h5);
            chkVal(out6DividerValue[33:32], c[1:0]);
            shadow[6] = host.phaseByte(c[1:0]);
            shadow[8] = {c[1:0], 3'h0, c[2:0]};
            shadow[2] = {3'h0, c[1:0], c[2:0]};
            shadow[7] = {c[1:0], 6'h3F};
        end
        foreach (addrs[i]) begin
            d = addrs[i] + 8'h01;
            host.wr((d == 8'h3E || d == 8'h46) ? d : 8'h3F, 8'hA5);
            host.rd(8'h3E, rdByte, rdOk);
            chkVal({rdOk, rdByte}, 9'h100);
        end
        checkAll();
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        checkAll();
        closeOut();
    end
endmodule

// File: logic/odc_cfg.svh
`ifndef ODC_CFG_SVH
`define ODC_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ODC_ADDR_O5_PHASE    8'h3B
`define ODC_ADDR_O5_DELAY    8'h3C
`define ODC_ADDR_O5_SUPDRV   8'h3D
`define ODC_ADDR_O6_DIVHI    8'h40
`define ODC_ADDR_O6_DIVMID   8'h41
`define ODC_ADDR_O6_DIVLO    8'h42
`define ODC_ADDR_O6_PHASE    8'h43
`define ODC_ADDR_O6_DELAY    8'h44
`define ODC_ADDR_O6_SUPDRV   8'h45

// ---------------------------------------------------------------
// register storage indices
// ---------------------------------------------------------------
`define ODC_NUM_REGS         9
`define ODC_IDX_O5_PHASE     4'h0
`define ODC_IDX_O5_DELAY     4'h1
`define ODC_IDX_O5_SUPDRV    4'h2
`define ODC_IDX_O6_DIVHI     4'h3
`define ODC_IDX_O6_DIVMID    4'h4
`define ODC_IDX_O6_DIVLO     4'h5
`define ODC_IDX_O6_PHASE     4'h6
`define ODC_IDX_O6_DELAY     4'h7
`define ODC_IDX_O6_SUPDRV    4'h8
`define ODC_IDX_NONE         4'hF

// ---------------------------------------------------------------
// implemented bits per register, reset value
// ---------------------------------------------------------------
`define ODC_MASK_PHASE       8'hC7
`define ODC_MASK_DELAY       8'hFF
`define ODC_MASK_O5_SUPDRV   8'h1F
`define ODC_MASK_O6_SUPDRV   8'hDF
`define ODC_MASK_DIVHI       8'hFF
`define ODC_MASK_DIVBYTE     8'hFF
`define ODC_REG_RESET        8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ODC_PHASE_MSB        7
`define ODC_PHASE_LSB        6
`define ODC_STRENGTH_MSB     2
`define ODC_STRENGTH_LSB     0
`define ODC_COARSE_MSB       5
`define ODC_COARSE_LSB       0
`define ODC_FINE_MSB         7
`define ODC_FINE_LSB         6
`define ODC_SUPPLY_MSB       4
`define ODC_SUPPLY_LSB       3
`define ODC_DRIVER_MSB       2
`define ODC_DRIVER_LSB       0
`define ODC_WIDE_MSB         7
`define ODC_WIDE_LSB         6
`define ODC_DIVHI_MSB        3
`define ODC_DIVHI_LSB        0

// ---------------------------------------------------------------
// codes and steps
// ---------------------------------------------------------------
`define ODC_FINE_STEP_PS     7'h1E
`define ODC_DIV_GAP_BITS     12'h000
`define ODC_PHASE_NORMAL     2'h0
`define ODC_PHASE_BOTH_TRUE  2'h1
`define ODC_SUPPLY_1V8       2'h0
`define ODC_SUPPLY_2V5       2'h1
`define ODC_SUPPLY_3V3       2'h2
`define ODC_DRV_LVDS         3'h0
`define ODC_DRV_LVPECL_CM    3'h1
`define ODC_DRV_CML          3'h2
`define ODC_DRV_HCSL         3'h3
`define ODC_DRV_LVDS_BOOST   3'h4
`define ODC_DRV_LVPECL_NOCM  3'h5

`endif

// File: logic/odc_leg_select.sv
`timescale 1ns/1ps
`include "odc_cfg.svh"

module odc_leg_select (
    input  wire logic                 ref_clk,   // register clock
    input  wire logic                 sys_rst,   // async reset, high
    input  wire logic [1:0]           phaseCode, // phase select field
    output odc_pkg::odc_leg_type      legSel     // registered leg sources
);

    // ---------------------------------------------------------------
    // leg source decode
    // ---------------------------------------------------------------
    // code 0 keeps a normal pair, code 1 puts true on both legs,
    // codes 2 and 3 put the complement on both legs
    wire logic normalPair = (phaseCode == `ODC_PHASE_NORMAL);
    wire logic bothTrue   = (phaseCode == `ODC_PHASE_BOTH_TRUE);
    odc_pkg::odc_leg_type legD;
    assign legD.positiveLegSource = !(normalPair || bothTrue);
    assign legD.negativeLegSource = !bothTrue;

    // output flop
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            legSel <= '0;
        end else begin
            legSel <= legD;
        end
    end

endmodule

// File: logic/odc_output_config.sv
`timescale 1ns/1ps
`include "odc_cfg.svh"

module odc_output_config (
    input  wire logic                    ref_clk,          // register clock, 200 MHz
    input  wire logic                    sys_rst,          // async reset, high
    input  wire logic                    cfgWrEn,          // write strobe from serial port
    input  wire logic                    cfgRdEn,          // read strobe from serial port
    input  wire logic [7:0]              cfgAddr,          // register number
    input  wire logic [7:0]              cfgWrData,        // write byte
    output logic      [7:0]              cfgRdData,        // read byte, registered
    output logic                         cfgRdValid,       // read byte valid pulse
    output odc_pkg::odc_out_cfg_type     out5Cfg,          // decoded output 5 setup
    output odc_pkg::odc_out_cfg_type     out6Cfg,          // decoded output 6 setup
    output logic      [33:0]             out6DividerValue  // output 6 divider value
);

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------

    // maps a register number to its storage slot
    function automatic logic [3:0] regIndex(input logic [7:0] a);
        logic [3:0] idx;
        idx = `ODC_IDX_NONE;
        case (a)
            `ODC_ADDR_O5_PHASE:  idx = `ODC_IDX_O5_PHASE;
            `ODC_ADDR_O5_DELAY:  idx = `ODC_IDX_O5_DELAY;
            `ODC_ADDR_O5_SUPDRV: idx = `ODC_IDX_O5_SUPDRV;
            `ODC_ADDR_O6_DIVHI:  idx = `ODC_IDX_O6_DIVHI;
            `ODC_ADDR_O6_DIVMID: idx = `ODC_IDX_O6_DIVMID;
            `ODC_ADDR_O6_DIVLO:  idx = `ODC_IDX_O6_DIVLO;
            `ODC_ADDR_O6_PHASE:  idx = `ODC_IDX_O6_PHASE;
            `ODC_ADDR_O6_DELAY:  idx = `ODC_IDX_O6_DELAY;
            `ODC_ADDR_O6_SUPDRV: idx = `ODC_IDX_O6_SUPDRV;
            default:             idx = `ODC_IDX_NONE;
        endcase
        return idx;
    endfunction

    // supply definition decode
    function automatic odc_pkg::odc_supply_type supplyDecode(input logic [1:0] code);
        odc_pkg::odc_supply_type s;
        s = odc_pkg::SUPPLY_UNDEFINED;
        case (code)
            `ODC_SUPPLY_1V8: s = odc_pkg::SUPPLY_1V8;
            `ODC_SUPPLY_2V5: s = odc_pkg::SUPPLY_2V5;
            `ODC_SUPPLY_3V3: s = odc_pkg::SUPPLY_3V3;
            default:         s = odc_pkg::SUPPLY_UNDEFINED;
        endcase
        return s;
    endfunction

    // driver standard decode
    function automatic odc_pkg::odc_driver_type driverDecode(input logic [2:0] code);
        odc_pkg::odc_driver_type d;
        d = odc_pkg::DRV_UNDEFINED;
        case (code)
            `ODC_DRV_LVDS:        d = odc_pkg::DRV_LVDS;
            `ODC_DRV_LVPECL_CM:   d = odc_pkg::DRV_LVPECL_CM;
            `ODC_DRV_CML:         d = odc_pkg::DRV_CML;
            `ODC_DRV_HCSL:        d = odc_pkg::DRV_HCSL;
            `ODC_DRV_LVDS_BOOST:  d = odc_pkg::DRV_LVDS_BOOST;
            `ODC_DRV_LVPECL_NOCM: d = odc_pkg::DRV_LVPECL_NOCM;
            default:              d = odc_pkg::DRV_UNDEFINED;
        endcase
        return d;
    endfunction

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------

    // implemented bits per slot; unimplemented bits never store
    localparam logic [7:0] WR_MASK [`ODC_NUM_REGS] = '{
        `ODC_MASK_PHASE,
        `ODC_MASK_DELAY,
        `ODC_MASK_O5_SUPDRV,
        `ODC_MASK_DIVHI,
        `ODC_MASK_DIVBYTE,
        `ODC_MASK_DIVBYTE,
        `ODC_MASK_PHASE,
        `ODC_MASK_DELAY,
        `ODC_MASK_O6_SUPDRV
    };

    logic [7:0] regQ [`ODC_NUM_REGS];  // configuration bytes
    wire  logic [3:0] wrIdx = regIndex(cfgAddr);
    wire  logic [3:0] rdIdx = regIndex(cfgAddr);
    wire  logic       rdHit = (rdIdx != `ODC_IDX_NONE);

    // one byte register per slot, masked store
    genvar r;
    generate
        for (r = 0; r < `ODC_NUM_REGS; r++) begin : gRegs
            wire logic       sel = cfgWrEn && (wrIdx == 4'(r));
            wire logic [7:0] d   = sel ? (cfgWrData & WR_MASK[r]) : regQ[r];
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    regQ[r] <= `ODC_REG_RESET;
                end else begin
                    regQ[r] <= d;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // read back
    // ---------------------------------------------------------------

    // read returns the stored byte; unmapped numbers read zero
    wire logic [7:0] rdDataD  = rdHit ? regQ[rdIdx] : `ODC_REG_RESET;
    wire logic [7:0] rdNextD  = cfgRdEn ? rdDataD : cfgRdData;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfgRdData  <= `ODC_REG_RESET;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdData  <= rdNextD;
            cfgRdValid <= cfgRdEn;
        end
    end

    // ---------------------------------------------------------------
    // per-output decode
    // ---------------------------------------------------------------

    localparam logic [3:0] PHASE_IDX  [2] = '{`ODC_IDX_O5_PHASE,  `ODC_IDX_O6_PHASE};
    localparam logic [3:0] DELAY_IDX  [2] = '{`ODC_IDX_O5_DELAY,  `ODC_IDX_O6_DELAY};
    localparam logic [3:0] SUPDRV_IDX [2] = '{`ODC_IDX_O5_SUPDRV, `ODC_IDX_O6_SUPDRV};

    odc_pkg::odc_out_cfg_type outCfgQ [2];  // decoded state, registered, legs aside
    odc_pkg::odc_leg_type     legQ    [2];  // leg sources, flopped in the selector

    // width of everything below the leg field
    localparam int REST_W = $bits(odc_pkg::odc_out_cfg_type) - $bits(odc_pkg::odc_leg_type);

    genvar o;
    generate
        for (o = 0; o < 2; o++) begin : gOut
            wire logic [7:0] phaseReg  = regQ[PHASE_IDX[o]];
            wire logic [7:0] delayReg  = regQ[DELAY_IDX[o]];
            wire logic [7:0] supDrvReg = regQ[SUPDRV_IDX[o]];

            // field extraction
            wire logic [1:0] phaseCode = phaseReg[`ODC_PHASE_MSB:`ODC_PHASE_LSB];
            wire logic [2:0] strength  = phaseReg[`ODC_STRENGTH_MSB:`ODC_STRENGTH_LSB];
            wire logic [5:0] coarse    = delayReg[`ODC_COARSE_MSB:`ODC_COARSE_LSB];
            wire logic [1:0] fineCode  = delayReg[`ODC_FINE_MSB:`ODC_FINE_LSB];
            wire logic [1:0] supCode   = supDrvReg[`ODC_SUPPLY_MSB:`ODC_SUPPLY_LSB];
            wire logic [2:0] drvCode   = supDrvReg[`ODC_DRIVER_MSB:`ODC_DRIVER_LSB];

            // fine delay as picoseconds, code times step
            wire logic [6:0] finePs = 7'(fineCode * `ODC_FINE_STEP_PS);

            // enumerated supply and driver
            wire odc_pkg::odc_supply_type supD = supplyDecode(supCode);
            wire odc_pkg::odc_driver_type drvD = driverDecode(drvCode);

            // leg sources, registered inside the selector
            odc_leg_select uLegs (
                .ref_clk   (ref_clk),
                .sys_rst   (sys_rst),
                .phaseCode (phaseCode),
                .legSel    (legQ[o])
            );

            // remaining decoded fields
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    outCfgQ[o].driveStrength <= '0;
                    outCfgQ[o].coarseDelay   <= '0;
                    outCfgQ[o].fineDelayCode <= '0;
                    outCfgQ[o].fineDelayPs   <= '0;
                    outCfgQ[o].supply        <= odc_pkg::SUPPLY_1V8;
                    outCfgQ[o].supplyBad     <= 1'b0;
                    outCfgQ[o].driver        <= odc_pkg::DRV_LVDS;
                    outCfgQ[o].driverBad     <= 1'b0;
                end else begin
                    outCfgQ[o].driveStrength <= strength;
                    outCfgQ[o].coarseDelay   <= coarse;
                    outCfgQ[o].fineDelayCode <= fineCode;
                    outCfgQ[o].fineDelayPs   <= finePs;
                    outCfgQ[o].supply        <= supD;
                    outCfgQ[o].supplyBad     <= (supD == odc_pkg::SUPPLY_UNDEFINED);
                    outCfgQ[o].driver        <= drvD;
                    outCfgQ[o].driverBad     <= (drvD == odc_pkg::DRV_UNDEFINED);
                end
            end
        end
    endgenerate

    // legs come from the selector flops, the rest from the decode flops
    assign out5Cfg = {legQ[0], outCfgQ[0][REST_W-1:0]};
    assign out6Cfg = {legQ[1], outCfgQ[1][REST_W-1:0]};

    // ---------------------------------------------------------------
    // output 6 divider assembly
    // ---------------------------------------------------------------

    // bits 31:20 live in registers outside this bank and read as zero here
    wire logic [1:0]  wideBits = regQ[`ODC_IDX_O6_SUPDRV][`ODC_WIDE_MSB:`ODC_WIDE_LSB];
    wire logic [3:0]  divHigh  = regQ[`ODC_IDX_O6_DIVHI][`ODC_DIVHI_MSB:`ODC_DIVHI_LSB];
    wire logic [33:0] divD     = {wideBits,
                                  `ODC_DIV_GAP_BITS,
                                  divHigh,
                                  regQ[`ODC_IDX_O6_DIVMID],
                                  regQ[`ODC_IDX_O6_DIVLO]};

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            out6DividerValue <= '0;
        end else begin
            out6DividerValue <= divD;
        end
    end

endmodule

// File: logic/odc_pkg.sv
package odc_pkg;

    // supply rail that an output is told it sits on
    typedef enum logic [1:0] {
        SUPPLY_1V8,
        SUPPLY_2V5,
        SUPPLY_3V3,
        SUPPLY_UNDEFINED
    } odc_supply_type;

    // differential driver standard
    typedef enum logic [2:0] {
        DRV_LVDS,
        DRV_LVPECL_CM,
        DRV_CML,
        DRV_HCSL,
        DRV_LVDS_BOOST,
        DRV_LVPECL_NOCM,
        DRV_UNDEFINED
    } odc_driver_type;

    // leg source: 0 = true clock, 1 = complement clock
    typedef struct packed {
        logic positiveLegSource;
        logic negativeLegSource;
    } odc_leg_type;

    // decoded configuration of one output
    typedef struct packed {
        odc_leg_type    legs;
        logic [2:0]     driveStrength;
        logic [5:0]     coarseDelay;
        logic [1:0]     fineDelayCode;
        logic [6:0]     fineDelayPs;
        odc_supply_type supply;
        logic           supplyBad;
        odc_driver_type driver;
        logic           driverBad;
    } odc_out_cfg_type;

endpackage
